// [tb/codec_loopback.sv]
// Purpose: Far side codec model that loops the transmit line back to receive.
// Assumes: Codec shifts one bit per bit clock, aligned to the frame syncs.
// Notes: Outside a frame the line carries the inverse of the transmit bit.
`timescale 1ns/100ps
module codec_loopback (
   input wire logic frame_a_i,
   input wire logic frame_b_i,
   input wire logic txd_i,
   output logic rxd_o
);
   // ==========================================================
   // Echo path; released line never repeats the last valid bit
   assign rxd_o = (frame_a_i | frame_b_i) ? txd_i : ~txd_i;
endmodule

// [tb/testbench.sv]
// Purpose: Self-checking bench for the codec serial port.
// Assumes: Channel B alone is used, looped back through the codec model.
// Notes: A full frame rotates the shifter back to the value written.
`timescale 1ns/100ps
module testbench;
   logic clock_i, rst_i, strobe, wr, pin, ready, internal, pd, req, owned;
   logic sclk, txd, rxd, fsa, fsb, rxv;
   logic [2:0] addr;
   logic [15:0] wdata, rdata, wcfg;
   logic [16:0] rxw;
   int failures, checks;

   // ==========================================================
   // Design and far side model
   codec_serial_port i_codec_serial_port (.clock_i(clock_i), .rst_i(rst_i),
      .ext_addr_i(addr), .ext_strobe_i(strobe), .ext_write_i(wr), .ext_wdata_i(wdata),
      .ext_rdata_o(rdata), .ext_internal_o(internal), .wait_config_o(wcfg),
      .shared_irq_line_one_i(pin), .irq_pulldown_en_o(pd), .irq_line_one_req_o(req),
      .irq_owned_o(owned), .sclk_o(sclk), .txd_o(txd), .rxd_i(rxd),
      .frame_sync_chan_a_o(fsa), .frame_sync_chan_b_o(fsb), .rx_valid_o(rxv),
      .rx_ready_i(ready), .rx_data_o(rxw));
   codec_loopback i_codec_loopback (.frame_a_i(fsa), .frame_b_i(fsb), .txd_i(txd),
      .rxd_o(rxd));

   // ==========================================================
   // Shared helpers
   task close_out;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task chk(input logic ok, input string m);
      checks++;
      if (ok !== 1'b1)
      begin
         failures++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask

   // One bus access, called at a rising edge; returns at the taking edge
   task bus(input logic [2:0] a, input logic w, input logic [15:0] d, input logic ei);
      addr <= a;
      wr <= w;
      wdata <= d;
      strobe <= 1'b1;
      @(negedge clock_i);
      chk(internal === ei, "internal flag");
      @(posedge clock_i);
   endtask

   // Bounded wait for a frame sync B falling edge
   task wait_fall;
      logic prev;
      int n;
      prev = 1'b0;
      n = 0;
      while (!(prev === 1'b1 && fsb === 1'b0))
      begin
         prev = fsb;
         @(negedge clock_i);
         n++;
         if (n > 3000)
         begin
            chk(1'b0, "frame end missing");
            close_out;
         end
      end
   endtask

   // ==========================================================
   // Scenarios
   task test_reset;
      @(negedge clock_i);
      chk(sclk === 1'b0 && fsa === 1'b0 && fsb === 1'b0, "idle link");
      chk(owned === 1'b0 && rxv === 1'b0 && pd === 1'b1, "reset state");
      @(posedge clock_i);
      pin <= 1'b1;
      repeat (3) @(negedge clock_i);
      chk(req === 1'b1, "pin not passed through");
      @(posedge clock_i);
      bus(codec_port_pkg::ADDR_CHAN0, 1'b1, 16'h1234, 1'b0);
      strobe <= 1'b0;
      $display("test reset done");
   endtask

   task test_mode(input logic [1:0] m, input logic p, input logic [15:0] w);
      logic [15:0] cfg;
      logic prev;
      int pulses, n, quiet, rises;
      cfg = 16'h000E;
      cfg[codec_port_pkg::CFG_CHAN1_EN_BIT] = 1'b1;
      cfg[codec_port_pkg::CFG_MODE_LSB +: 2] = m;
      @(posedge clock_i);
      pin <= p;
      ready <= 1'b1;
      repeat (3) @(posedge clock_i);
      bus(codec_port_pkg::ADDR_CONFIG, 1'b1, 16'h0000, 1'b1);
      bus(codec_port_pkg::ADDR_CONFIG, 1'b1, 16'h0A5A, 1'b1);
      bus(codec_port_pkg::ADDR_CONFIG, 1'b1, cfg, 1'b1);
      bus(codec_port_pkg::ADDR_CONFIG, 1'b1, 16'h0A5A, 1'b1);
      strobe <= 1'b0;
      pulses = 0;
      repeat (6)
      begin
         @(negedge clock_i);
         pulses += (req === 1'b1);
      end
      chk(pulses == (p ? 0 : 1), "enable interrupt count");
      chk(wcfg === 16'h0A5A && owned === 1'b1, "config or ownership");
      // Setting 14 divides by 16-14=2: one bit clock every 2*2*2 clocks
      prev = sclk;
      rises = 0;
      repeat (64)
      begin
         @(negedge clock_i);
         rises += (sclk === 1'b1 && prev === 1'b0);
         prev = sclk;
      end
      chk(rises == 8, "bit clock period");
      wait_fall;
      @(negedge clock_i);
      chk(req === 1'b1, "frame end interrupt");
      @(negedge clock_i);
      chk(req === 1'b0, "interrupt longer than one cycle");
      @(posedge clock_i);
      bus(codec_port_pkg::ADDR_CHAN1, 1'b0, 16'h0000, 1'b1);
      bus(codec_port_pkg::ADDR_CHAN1, 1'b1, w, 1'b1);
      bus(codec_port_pkg::ADDR_CHAN1, 1'b0, 16'h0000, 1'b1);
      bus(codec_port_pkg::ADDR_CHAN1, 1'b1, w, 1'b1);
      bus(codec_port_pkg::ADDR_CHAN1, 1'b0, 16'h0000, 1'b1);
      strobe <= 1'b0;
      @(negedge clock_i);
      chk(rdata === w, "first stage read");
      @(posedge clock_i);
      bus(codec_port_pkg::ADDR_CHAN1, 1'b0, 16'h0000, 1'b1);
      strobe <= 1'b0;
      ready <= 1'b0;
      @(negedge clock_i);
      chk(rdata === w, "read changed stage");
      n = 0;
      quiet = 0;
      while (quiet < 300)
      begin
         @(negedge clock_i);
         quiet = (fsb === 1'b0) ? quiet + 1 : 0;
         n++;
         if (n > 20000)
         begin
            chk(1'b0, "buffer never filled");
            close_out;
         end
      end
      chk(rxv === 1'b1 && fsa === 1'b0, "stall state");
      @(posedge clock_i);
      ready <= 1'b1;
      n = 0;
      repeat (24)
      begin
         @(negedge clock_i);
         if (rxv === 1'b1)
         begin
            n++;
            chk(rxw === {1'b1, w}, "received word");
         end
      end
      chk(n == 16 && rxv === 1'b0, "buffer drain count");
      $display("test mode %0d done", m);
   endtask

   // ==========================================================
   // Clock, reset and main sequence
   initial
   begin
      clock_i = 1'b0;
      forever #2 clock_i = ~clock_i;
   end

   initial
   begin
      failures = 0;
      checks = 0;
      rst_i = 1'b1;
      strobe = 1'b0;
      wr = 1'b0;
      addr = 3'h0;
      wdata = 16'h0000;
      pin = 1'b0;
      ready = 1'b1;
      repeat (6) @(posedge clock_i);
      rst_i <= 1'b0;
      test_reset;
      test_mode(codec_port_pkg::MODE_8, 1'b0, 16'h8D3C);
      test_mode(codec_port_pkg::MODE_16, 1'b1, 16'hB1E7);
      test_mode(codec_port_pkg::MODE_64, 1'b0, 16'hC35A);
      close_out;
   end
endmodule

// [verilog/codec_port_pkg.sv]
// Purpose: Shared constants and types of the codec serial port.
// Assumes: Core side register addresses are 3-bit peripheral addresses.
// Notes: Field positions of the port control word live here only.
package codec_port_pkg;

   // ==========================================================
   // Register addresses on the core peripheral bus
   localparam logic [2:0] ADDR_CHAN0 = 3'h5;
   localparam logic [2:0] ADDR_CHAN1 = 3'h6;
   localparam logic [2:0] ADDR_CONFIG = 3'h7;

   // ==========================================================
   // Widths and buffer sizes
   localparam int WORD_W = 16;
   localparam int STREAM_W = 17;
   localparam int STREAM_DEPTH = 16;

   // ==========================================================
   // Port control word (first configuration stage)
   localparam int CFG_CHAN0_EN_BIT = 15;
   localparam int CFG_CHAN1_EN_BIT = 14;
   localparam int CFG_MODE_LSB = 12;
   localparam int CFG_PS_LSB = 0;
   localparam logic [15:0] CFG_RESET = 16'h0000;
   localparam logic [15:0] DATA_RESET = 16'h0000;

   // ==========================================================
   // Word length modes and frame lengths in bits
   localparam logic [1:0] MODE_8 = 2'h0;
   localparam logic [1:0] MODE_16 = 2'h1;
   localparam logic [1:0] MODE_64 = 2'h2;
   localparam logic [6:0] LEN_8 = 7'h08;
   localparam logic [6:0] LEN_16 = 7'h10;
   localparam logic [6:0] LEN_64 = 7'h40;

   // ==========================================================
   // Prescaler terminal count
   localparam logic [3:0] PS_TOP = 4'hf;

   // Frame sequencer states, Gray along idle, A, B, done
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CHAN_A = 2'b01,
      ST_CHAN_B = 2'b11,
      ST_DONE = 2'b10
   } frame_state_t;

endpackage

// [verilog/codec_serial_port.sv]
// Purpose: Dual channel master codec serial port with two-stage registers.
// Assumes: Core reaches the port through its 3-bit peripheral bus.
// Notes: Received frame words are also streamed out through a FIFO.
`timescale 1ns/100ps

module codec_serial_port (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic [2:0] ext_addr_i,
   input wire logic ext_strobe_i,
   input wire logic ext_write_i,
   input wire logic [15:0] ext_wdata_i,
   output logic [15:0] ext_rdata_o,
   output logic ext_internal_o,
   output logic [15:0] wait_config_o,
   input wire logic shared_irq_line_one_i,
   output logic irq_pulldown_en_o,
   output logic irq_line_one_req_o,
   output logic irq_owned_o,
   output logic sclk_o,
   output logic txd_o,
   input wire logic rxd_i,
   output logic frame_sync_chan_a_o,
   output logic frame_sync_chan_b_o,
   output logic rx_valid_o,
   input wire logic rx_ready_i,
   output logic [16:0] rx_data_o
);
   logic [15:0] chan0_stage_first_q;
   logic [15:0] chan0_stage_second_q;
   logic [15:0] chan1_stage_first_q;
   logic [15:0] chan1_stage_second_q;
   logic [15:0] cfg_first_q;
   logic [15:0] cfg_second_q;
   logic chan0_en;
   logic chan1_en;
   logic enabled;
   logic [1:0] mode;
   logic [3:0] bit_clock_prescale;
   logic [6:0] frame_len;
   logic acc_c0;
   logic acc_c1;
   logic acc_cfg;
   logic wr_c0;
   logic wr_c1;
   logic div2_q;
   logic [3:0] pre_cnt_q;
   logic sclk_q;
   logic tick;
   logic rise_ev;
   logic fall_ev;
   logic rxd_meta_q;
   logic rxd_sync_q;
   logic pin_meta_q;
   logic pin_sync_q;
   codec_port_pkg::frame_state_t state_q;
   logic in_a;
   logic in_b;
   logic [15:0] rx_word_a;
   logic [15:0] rx_word_b;
   logic [6:0] bit_cnt_q;
   logic after_a_q;
   logic last_bit;
   logic frame_end;
   logic txd_q;
   logic [63:0] chain;
   logic [63:0] chain_shift;
   logic sync_b_prev_q;
   logic en_prev_q;
   logic irq_pulse_q;
   logic [15:0] rdata_q;
   word_stream_if #(.W(codec_port_pkg::STREAM_W)) rx_stream ();

   // ==========================================================
   // Decode of the port control word
   assign chan0_en = cfg_first_q[codec_port_pkg::CFG_CHAN0_EN_BIT];
   assign chan1_en = cfg_first_q[codec_port_pkg::CFG_CHAN1_EN_BIT];
   assign enabled = chan0_en || chan1_en;
   assign mode = cfg_first_q[codec_port_pkg::CFG_MODE_LSB +: 2];
   assign bit_clock_prescale = cfg_first_q[codec_port_pkg::CFG_PS_LSB +: 4];
   assign wait_config_o = cfg_second_q;

   // Frame length from word length mode
   always_comb
   begin
      case (mode)
         codec_port_pkg::MODE_16: frame_len = codec_port_pkg::LEN_16;
         codec_port_pkg::MODE_64: frame_len = codec_port_pkg::LEN_64;
         default: frame_len = codec_port_pkg::LEN_8;
      endcase
   end

   // ==========================================================
   // Core bus decode; enabled channels stay off the external bus
   assign acc_c0 = (ext_addr_i == codec_port_pkg::ADDR_CHAN0) && chan0_en;
   assign acc_c1 = (ext_addr_i == codec_port_pkg::ADDR_CHAN1) && chan1_en;
   assign acc_cfg = (ext_addr_i == codec_port_pkg::ADDR_CONFIG);
   assign ext_internal_o = ext_strobe_i && (acc_c0 || acc_c1 || acc_cfg);
   assign wr_c0 = ext_strobe_i && ext_write_i && acc_c0;
   assign wr_c1 = ext_strobe_i && ext_write_i && acc_c1;

   // Read data: first stage only, nothing moves
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         rdata_q <= codec_port_pkg::DATA_RESET;
      end
      else if (ext_strobe_i && !ext_write_i)
      begin
         if (acc_c0)
            rdata_q <= chan0_stage_first_q;
         else if (acc_c1)
            rdata_q <= chan1_stage_first_q;
         else if (acc_cfg)
            rdata_q <= cfg_first_q;
      end
   end
   assign ext_rdata_o = rdata_q;

   // Configuration FIFO: second write pushes the first word down
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         cfg_first_q <= codec_port_pkg::CFG_RESET;
         cfg_second_q <= codec_port_pkg::CFG_RESET;
      end
      else if (ext_strobe_i && ext_write_i && acc_cfg)
      begin
         cfg_first_q <= cfg_second_q;
         cfg_second_q <= ext_wdata_i;
      end
   end

   // ==========================================================
   // Pin synchronisers
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         rxd_meta_q <= 1'b0;
         rxd_sync_q <= 1'b0;
         pin_meta_q <= 1'b0;
         pin_sync_q <= 1'b0;
      end
      else
      begin
         rxd_meta_q <= rxd_i;
         rxd_sync_q <= rxd_meta_q;
         pin_meta_q <= shared_irq_line_one_i;
         pin_sync_q <= pin_meta_q;
      end
   end

   // ==========================================================
   // Bit clock: halve, then prescaler from the setting up to all ones
   assign tick = enabled && div2_q && (pre_cnt_q == codec_port_pkg::PS_TOP);
   assign rise_ev = tick && !sclk_q;
   assign fall_ev = tick && sclk_q;

   always_ff @(posedge clock_i)
   begin
      if (rst_i || !enabled)
      begin
         div2_q <= 1'b0;
         pre_cnt_q <= codec_port_pkg::PS_TOP;
         sclk_q <= 1'b0;
      end
      else
      begin
         div2_q <= !div2_q;
         if (div2_q)
         begin
            if (pre_cnt_q == codec_port_pkg::PS_TOP)
            begin
               pre_cnt_q <= bit_clock_prescale;
               sclk_q <= !sclk_q;
            end
            else
            begin
               pre_cnt_q <= 4'(pre_cnt_q + 4'h1);
            end
         end
      end
   end
   assign sclk_o = sclk_q;

   // ==========================================================
   // Frame sequencer: channel A frame, then channel B frame; 64 bit mode runs channel B frames only
   assign in_a = (state_q == codec_port_pkg::ST_CHAN_A);
   assign in_b = (state_q == codec_port_pkg::ST_CHAN_B);
   assign last_bit = fall_ev && (bit_cnt_q == 7'(frame_len - 7'h01));
   assign frame_end = last_bit && (in_a || in_b);

   always_ff @(posedge clock_i)
   begin
      if (rst_i || !enabled)
      begin
         state_q <= codec_port_pkg::ST_IDLE;
         bit_cnt_q <= 7'h00;
         after_a_q <= 1'b0;
      end
      else
      begin
         case (state_q)
            codec_port_pkg::ST_IDLE:
            begin
               bit_cnt_q <= 7'h00;
               // Start only with room for the frame word downstream
               if (fall_ev && rx_stream.ready)
               begin
                  if (mode == codec_port_pkg::MODE_64)
                  begin
                     if (chan1_en)
                        state_q <= codec_port_pkg::ST_CHAN_B;
                  end
                  else if (chan0_en && !after_a_q)
                     state_q <= codec_port_pkg::ST_CHAN_A;
                  else if (chan1_en)
                     state_q <= codec_port_pkg::ST_CHAN_B;
                  after_a_q <= 1'b0;
               end
            end
            codec_port_pkg::ST_CHAN_A:
            begin
               if (fall_ev)
                  bit_cnt_q <= 7'(bit_cnt_q + 7'h01);
               if (last_bit)
               begin
                  state_q <= codec_port_pkg::ST_IDLE;
                  after_a_q <= 1'b1;
               end
            end
            codec_port_pkg::ST_CHAN_B:
            begin
               if (fall_ev)
                  bit_cnt_q <= 7'(bit_cnt_q + 7'h01);
               if (last_bit)
                  state_q <= codec_port_pkg::ST_DONE;
            end
            default:
            begin
               state_q <= codec_port_pkg::ST_IDLE;
            end
         endcase
      end
   end
   assign frame_sync_chan_a_o = in_a;
   assign frame_sync_chan_b_o = in_b;

   // ==========================================================
   // Shift paths; 64 bit chain runs A first, A second, B first, B second
   assign chain = {chan0_stage_first_q, chan0_stage_second_q,
                   chan1_stage_first_q, chan1_stage_second_q};
   assign chain_shift = {chain[62:0], rxd_sync_q};

   // Transmit bit driven on the bit clock rise, MSB first
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         txd_q <= 1'b0;
      end
      else if (rise_ev)
      begin
         if (in_b && mode == codec_port_pkg::MODE_64)
            txd_q <= chain[63];
         else if (in_a && mode == codec_port_pkg::MODE_8)
            txd_q <= chan0_stage_second_q[7];
         else if (in_a)
            txd_q <= chan0_stage_second_q[15];
         else if (in_b && mode == codec_port_pkg::MODE_8)
            txd_q <= chan1_stage_second_q[7];
         else if (in_b)
            txd_q <= chan1_stage_second_q[15];
      end
   end
   assign txd_o = txd_q;

   // Channel A pair: core write pushes, falls shift the second stage
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         chan0_stage_first_q <= codec_port_pkg::DATA_RESET;
         chan0_stage_second_q <= codec_port_pkg::DATA_RESET;
      end
      else if (wr_c0)
      begin
         chan0_stage_first_q <= chan0_stage_second_q;
         chan0_stage_second_q <= ext_wdata_i;
      end
      else if (fall_ev && in_b && mode == codec_port_pkg::MODE_64)
      begin
         chan0_stage_first_q <= chain_shift[63:48];
         chan0_stage_second_q <= chain_shift[47:32];
      end
      else if (fall_ev && in_a && mode == codec_port_pkg::MODE_8)
      begin
         chan0_stage_second_q[7:0] <= {chan0_stage_second_q[6:0], rxd_sync_q};
      end
      else if (fall_ev && in_a)
      begin
         chan0_stage_second_q <= {chan0_stage_second_q[14:0], rxd_sync_q};
      end
   end

   // Channel B pair, same structure
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         chan1_stage_first_q <= codec_port_pkg::DATA_RESET;
         chan1_stage_second_q <= codec_port_pkg::DATA_RESET;
      end
      else if (wr_c1)
      begin
         chan1_stage_first_q <= chan1_stage_second_q;
         chan1_stage_second_q <= ext_wdata_i;
      end
      else if (fall_ev && in_b && mode == codec_port_pkg::MODE_64)
      begin
         chan1_stage_first_q <= chain_shift[31:16];
         chan1_stage_second_q <= chain_shift[15:0];
      end
      else if (fall_ev && in_b && mode == codec_port_pkg::MODE_8)
      begin
         chan1_stage_second_q[7:0] <= {chan1_stage_second_q[6:0], rxd_sync_q};
      end
      else if (fall_ev && in_b)
      begin
         chan1_stage_second_q <= {chan1_stage_second_q[14:0], rxd_sync_q};
      end
   end

   // ==========================================================
   // Received word stream: channel flag and last shifted word
   assign rx_stream.valid = frame_end;
   // 8 bit mode keeps the upper byte untouched in the streamed word
   assign rx_word_a = (mode == codec_port_pkg::MODE_8) ?
      {chan0_stage_second_q[15:8], chan0_stage_second_q[6:0], rxd_sync_q} :
      {chan0_stage_second_q[14:0], rxd_sync_q};
   assign rx_word_b = (mode == codec_port_pkg::MODE_8) ?
      {chan1_stage_second_q[15:8], chan1_stage_second_q[6:0], rxd_sync_q} :
      {chan1_stage_second_q[14:0], rxd_sync_q};
   assign rx_stream.data = in_a ? {1'b0, rx_word_a} : {1'b1, rx_word_b};

   word_fifo #(
      .WIDTH(codec_port_pkg::STREAM_W),
      .DEPTH(codec_port_pkg::STREAM_DEPTH)
   ) rx_fifo (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .fill(rx_stream.consumer),
      .drain_valid_o(rx_valid_o),
      .drain_ready_i(rx_ready_i),
      .drain_data_o(rx_data_o)
   );

   // ==========================================================
   // Line one interrupt: channel B frame end pulse, plus first-enable pulse
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         sync_b_prev_q <= 1'b0;
         en_prev_q <= 1'b0;
         irq_pulse_q <= 1'b0;
      end
      else
      begin
         sync_b_prev_q <= frame_sync_chan_b_o;
         en_prev_q <= enabled;
         irq_pulse_q <= (sync_b_prev_q && !frame_sync_chan_b_o)
            || (enabled && !en_prev_q && !pin_sync_q);
      end
   end
   assign irq_owned_o = enabled;
   assign irq_line_one_req_o = enabled ? irq_pulse_q : pin_sync_q;
   assign irq_pulldown_en_o = 1'b1;

   // ==========================================================
   // Checks
   chk_irq_on_sync_fall: assert property (@(posedge clock_i) disable iff (rst_i)
      enabled && $fell(frame_sync_chan_b_o) |=> irq_line_one_req_o)
      else $error("no interrupt after frame sync B fall");
   chk_irq_pin_passed: assert property (@(posedge clock_i) disable iff (rst_i)
      !enabled |-> irq_line_one_req_o == pin_sync_q && !irq_owned_o)
      else $error("disabled port did not pass line one");
   chk_reset_disabled: assert property (@(posedge clock_i) disable iff (rst_i)
      $fell(rst_i) |-> !enabled && !frame_sync_chan_a_o && !sclk_o)
      else $error("port not disabled after reset");
   chk_pin_high_quiet: assert property (@(posedge clock_i) disable iff (rst_i)
      $rose(enabled) && pin_sync_q |=> !irq_pulse_q)
      else $error("extra interrupt with pin high");
   chk_first_enable_irq: assert property (@(posedge clock_i) disable iff (rst_i)
      $rose(enabled) && !pin_sync_q |=> irq_pulse_q ##1 !irq_pulse_q)
      else $error("missing first enable interrupt");
   chk_read_keeps_fifo: assert property (@(posedge clock_i) disable iff (rst_i)
      ext_strobe_i && !ext_write_i && acc_c1 && mode != codec_port_pkg::MODE_64
      |=> $stable(chan1_stage_first_q) && rdata_q == $past(chan1_stage_first_q))
      else $error("read changed the data FIFO");
   chk_write_pushes: assert property (@(posedge clock_i) disable iff (rst_i)
      wr_c1 |=> chan1_stage_first_q == $past(chan1_stage_second_q)
      && chan1_stage_second_q == $past(ext_wdata_i))
      else $error("write did not push the data FIFO");
   chk_cfg_two_writes: assert property (@(posedge clock_i) disable iff (rst_i)
      ext_strobe_i && ext_write_i && acc_cfg ##1 ext_strobe_i && ext_write_i && acc_cfg
      |=> cfg_first_q == $past(ext_wdata_i, 2) && cfg_second_q == $past(ext_wdata_i))
      else $error("configuration words not stacked");
   chk_low_byte_shift: assert property (@(posedge clock_i) disable iff (rst_i)
      fall_ev && in_b && mode == codec_port_pkg::MODE_8 && !wr_c1
      |=> $stable(chan1_stage_second_q[15:8])
      && chan1_stage_second_q[0] == $past(rxd_sync_q))
      else $error("8 bit receive left the low byte");
   chk_tx_msb_first: assert property (@(posedge clock_i) disable iff (rst_i)
      rise_ev && in_b && mode == codec_port_pkg::MODE_16
      |=> txd_o == $past(chan1_stage_second_q[15]))
      else $error("transmit bit is not the MSB");
   chk_internal_access: assert property (@(posedge clock_i) disable iff (rst_i)
      ext_strobe_i && ext_addr_i == codec_port_pkg::ADDR_CHAN1 |-> ext_internal_o == chan1_en)
      else $error("channel access routing wrong");
   cov_frame_a_then_b: cover property (@(posedge clock_i) disable iff (rst_i)
      $fell(frame_sync_chan_a_o) ##[1:300] $rose(frame_sync_chan_b_o));
   cov_frame_64: cover property (@(posedge clock_i) disable iff (rst_i)
      frame_end && mode == codec_port_pkg::MODE_64);
   cov_first_enable: cover property (@(posedge clock_i) disable iff (rst_i)
      $rose(enabled) && !pin_sync_q);
endmodule

// [verilog/word_fifo.sv]
// Purpose: Parameterised synchronous FIFO for received words.
// Assumes: Single clock, synchronous active high reset.
// Notes: Ready falls when full, so the filler stalls.
`timescale 1ns/100ps
module word_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 16
) (
   input wire logic clock_i,
   input wire logic rst_i,
   word_stream_if.consumer fill,
   output logic drain_valid_o,
   input wire logic drain_ready_i,
   output logic [WIDTH-1:0] drain_data_o
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [AW:0] count_q;
   logic push;
   logic pop;

   // ==========================================================
   // Handshakes
   assign fill.ready = (count_q != FULL_COUNT);
   assign drain_valid_o = (count_q != '0);
   assign drain_data_o = mem_q[rd_ptr_q];
   assign push = fill.valid && fill.ready;
   assign pop = drain_valid_o && drain_ready_i;

   // Storage write
   always_ff @(posedge clock_i)
   begin
      if (push)
      begin
         mem_q[wr_ptr_q] <= fill.data;
      end
   end

   // Pointers and occupancy
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_q <= AW'(wr_ptr_q + 1'b1);
         end
         if (pop)
         begin
            rd_ptr_q <= AW'(rd_ptr_q + 1'b1);
         end
         count_q <= (AW+1)'(count_q + push - pop);
      end
   end

   // ==========================================================
   // Checks
   chk_fifo_no_overflow: assert property (@(posedge clock_i) disable iff (rst_i)
      count_q == FULL_COUNT && !pop |=> count_q == FULL_COUNT)
      else $error("fifo occupancy moved while full");
   cov_fifo_full: cover property (@(posedge clock_i) disable iff (rst_i)
      count_q == FULL_COUNT);
endmodule

// [verilog/word_stream_if.sv]
// Purpose: Valid/ready word stream between port and receive buffer.
// Assumes: Both ends run on the same clock.
// Notes: Producer drives valid and data, consumer drives ready.
`timescale 1ns/100ps
interface word_stream_if #(parameter int W = 17);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport producer (output valid, output data, input ready);
   modport consumer (input valid, input data, output ready);
endinterface
